// ### hw/lcdc_decoder.sv
// What this block does
// [R1] Select low marks a command byte; high marks a display data byte.
// [R2] 0xA6 lights RAM-high pixels, 0xA7 lights RAM-low pixels; RAM untouched.
// [R3] 0xA5 forces all pixels lit, 0xA4 returns to RAM display.
// [R4] All-pixels-on overrides normal or inverse selection.
// [R5] 0xA2 selects 1/9 bias, 0xA3 1/7; effective only with follower running.
// [R6] In read-modify-write, column advances on data writes only, not reads.
// [R7] 0xEE ends read-modify-write and restores the saved column address.
// [R8] Host must not set column address during read-modify-write.
// [R9] 0xE2 restores defaults except inverse, all-on and bias, and cancels read-modify-write and test modes.
// [R10] Software reset leaves display RAM contents untouched.
// [R11] Host must use hardware reset pin at power-up.
// [R12] 0xC0-0xC7 scan commons upward, 0xC8-0xCF downward.
// [R13] 0x20-0x27 load the 3-bit regulator resistor ratio.
// [R14] After 0x81 the next byte is only a contrast load.
// [R15] Contrast byte loads its low six bits; pending mode then clears.
// [R16] Host sends contrast mode and value bytes back to back.
// [R17] 0xAC turns indicator off alone; 0xAD turns it on, expects a byte.
// [R18] After 0xAD only the indicator register byte is accepted next.
// [R19] Indicator state changes only by its own commands, 0xE2 and reset.
// [R20] Indicator drives two electrode outputs from the static drive.
// [R21] Indicator byte low two bits: off, 0.5 s blink, 1 s blink, steady.
// [R22] Command bytes are captured at write strobe end and decoded in order.
`timescale 1ns/10ps
`default_nettype none
module lcdc_decoder (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hard_init_pin_n,
    input wire logic host_wr_n,
    input wire logic host_rd_n,
    input wire logic cmd_data_select,
    input wire logic [7:0] host_data,
    input wire logic follower_on,
    input wire logic static_frame,
    input wire logic ram_bit,
    output logic pixel_drive,
    output logic inverse_on,
    output logic all_on,
    output logic bias_seventh,
    output logic bias_active,
    output logic scan_reverse,
    output logic [lcdc_pkg::RATIO_W-1:0] regulator_resistor_ratio,
    output logic [lcdc_pkg::CONTRAST_W-1:0] lcd_drive_level,
    output logic [lcdc_pkg::COL_W-1:0] column_addr,
    output logic rmw_active,
    output logic test_active,
    output logic soft_reset_pulse,
    output logic indicator_on,
    output logic [lcdc_pkg::IND_W-1:0] indicator_mode,
    output logic indicator_electrode_a,
    output logic indicator_electrode_b
);
    import lcdc_pkg::*;
    typedef struct packed {
        lcdc_state_t st;
        logic inverse;
        logic all_on;
        logic bias7;
        logic scan_rev;
        logic [RATIO_W-1:0] ratio;
        logic [CONTRAST_W-1:0] contrast;
        logic [COL_W-1:0] col;
        logic [COL_W-1:0] col_saved;
        logic rmw;
        logic test;
        logic srst;
        logic ind_on;
        logic [IND_W-1:0] ind_mode;
        logic init_n_seen;
    } lcdc_dec_t;
    lcdc_dec_t q, d;
    logic wr_level, wr_rise, rd_level, rd_rise, sel_level, init_n_level;
    logic [7:0] data_q;
    logic wr_done, rd_done, cmd_wr, data_wr;
    lcdc_col_op_t col_op;

    // Masked compare for grouped command bytes
    function automatic logic cmd_match(input logic [7:0] b, input logic [7:0] base, input logic [7:0] mask);
        cmd_match = ((b & mask) == base);
    endfunction

    // Strobes and select come from the host pins
    lcdc_strobe_sync u_wr_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in(host_wr_n),
        .level_out(wr_level),
        .rise_pulse(wr_rise)
    );
    lcdc_strobe_sync u_rd_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in(host_rd_n),
        .level_out(rd_level),
        .rise_pulse(rd_rise)
    );
    lcdc_strobe_sync #(.IDLE_LVL(1'b0)) u_sel_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in(cmd_data_select),
        .level_out(sel_level),
        .rise_pulse()
    );
    lcdc_strobe_sync #(.IDLE_LVL(1'b0)) u_init_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in(hard_init_pin_n),
        .level_out(init_n_level),
        .rise_pulse()
    );

    // Data bus held stable by host across strobe end; sampled while strobe low
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            data_q <= 8'h00;
        end else if (!wr_level) begin
            data_q <= host_data;
        end
    end

    // Strobe completion classified by select level
    assign wr_done = wr_rise & q.init_n_seen;
    assign rd_done = rd_rise & q.init_n_seen;
    assign cmd_wr = wr_done & ~sel_level; // R1 R22
    assign data_wr = wr_done & sel_level; // R1

    // Command decode, one byte per completed strobe
    always_comb begin
        d = q;
        col_op = LCDC_COL_HOLD;
        d.srst = 1'b0;
        d.init_n_seen = 1'b1;
        if (cmd_wr) begin
            case (q.st)
                LCDC_WAIT_CONTRAST: begin
                    d.contrast = data_q[CONTRAST_W-1:0]; // R14 R15
                    d.st = LCDC_IDLE; // R15
                end
                LCDC_WAIT_INDICATOR: begin
                    d.ind_mode = data_q[IND_W-1:0]; // R18 R21
                    d.st = LCDC_IDLE; // R18
                end
                default: begin
                    d.st = LCDC_IDLE;
                    case (data_q)
                        CMD_NORMAL: d.inverse = 1'b0; // R2
                        CMD_INVERSE: d.inverse = 1'b1; // R2
                        CMD_ALL_OFF: d.all_on = 1'b0; // R3
                        CMD_ALL_ON: d.all_on = 1'b1; // R3
                        CMD_BIAS_9: d.bias7 = 1'b0; // R5
                        CMD_BIAS_7: d.bias7 = 1'b1; // R5
                        CMD_RMW: begin
                            d.rmw = 1'b1;
                            d.col_saved = q.col;
                        end
                        CMD_RMW_END: begin
                            if (q.rmw) begin
                                col_op = LCDC_COL_RESTORE; // R7
                            end
                            d.rmw = 1'b0; // R7
                        end
                        CMD_SW_RESET: begin
                            // Display RAM is outside this block and is not touched
                            d.scan_rev = 1'b0; // R9 R10
                            d.ratio = RATIO_RST; // R9
                            d.contrast = CONTRAST_RST; // R9
                            d.ind_on = 1'b0; // R9
                            d.ind_mode = IND_RST; // R9
                            d.rmw = 1'b0; // R9
                            d.test = 1'b0; // R9
                            d.srst = 1'b1; // R9
                            col_op = LCDC_COL_CLEAR; // R9
                        end
                        CMD_NOP: d.test = 1'b0;
                        CMD_CONTRAST_MODE: d.st = LCDC_WAIT_CONTRAST; // R14
                        CMD_IND_OFF: d.ind_on = 1'b0; // R17 R19
                        CMD_IND_ON: begin
                            d.ind_on = 1'b1; // R17
                            d.st = LCDC_WAIT_INDICATOR; // R17
                        end
                        default: begin
                            if (cmd_match(data_q, CMD_SCAN_BASE, CMD_SCAN_MASK)) begin
                                d.scan_rev = data_q[SCAN_DIR_BIT]; // R12
                            end else if (cmd_match(data_q, CMD_RATIO_BASE, CMD_RATIO_MASK)) begin
                                d.ratio = data_q[RATIO_W-1:0]; // R13
                            end else if (cmd_match(data_q, CMD_TEST_BASE, CMD_TEST_MASK)) begin
                                d.test = 1'b1;
                            end else if (cmd_match(data_q, CMD_COLH_BASE, CMD_COL_MASK)) begin
                                col_op = LCDC_COL_LOAD_HI; // R8
                            end else if (cmd_match(data_q, CMD_COLL_BASE, CMD_COL_MASK)) begin
                                col_op = LCDC_COL_LOAD_LO; // R8
                            end
                        end
                    endcase
                end
            endcase
        end else if (data_wr) begin
            col_op = LCDC_COL_INC; // R6
        end else if (rd_done && sel_level && !q.rmw) begin
            col_op = LCDC_COL_INC; // R6
        end
        // Column counter stops at its top value
        case (col_op)
            LCDC_COL_INC: d.col = (q.col == {COL_W{1'b1}}) ? q.col : q.col + 1'b1;
            LCDC_COL_LOAD_HI: d.col = {data_q[3:0], q.col[3:0]};
            LCDC_COL_LOAD_LO: d.col = {q.col[7:4], data_q[3:0]};
            LCDC_COL_RESTORE: d.col = q.col_saved;
            LCDC_COL_CLEAR: d.col = COL_RST;
            default: d.col = q.col;
        endcase
    end

    // Hardware reset pin or system reset restores all defaults
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '{st: LCDC_IDLE, inverse: 1'b0, all_on: 1'b0, bias7: 1'b0, scan_rev: 1'b0,
                   ratio: RATIO_RST, contrast: CONTRAST_RST, col: COL_RST, col_saved: COL_RST,
                   rmw: 1'b0, test: 1'b0, srst: 1'b0, ind_on: 1'b0, ind_mode: IND_RST,
                   init_n_seen: 1'b0};
        end else if (!init_n_level) begin
            q <= '{st: LCDC_IDLE, inverse: 1'b0, all_on: 1'b0, bias7: 1'b0, scan_rev: 1'b0,
                   ratio: RATIO_RST, contrast: CONTRAST_RST, col: COL_RST, col_saved: COL_RST,
                   rmw: 1'b0, test: 1'b0, srst: 1'b0, ind_on: 1'b0, ind_mode: IND_RST,
                   init_n_seen: 1'b1}; // R11
        end else begin
            q <= d;
        end
    end

    // Pixel output: all-on wins, else RAM bit through inversion
    assign pixel_drive = q.all_on | (ram_bit ^ q.inverse); // R2 R3 R4
    assign inverse_on = q.inverse;
    assign all_on = q.all_on;
    assign bias_seventh = q.bias7;
    assign bias_active = follower_on; // R5
    assign scan_reverse = q.scan_rev;
    assign regulator_resistor_ratio = q.ratio;
    assign lcd_drive_level = q.contrast;
    assign column_addr = q.col;
    assign rmw_active = q.rmw;
    assign test_active = q.test;
    assign soft_reset_pulse = q.srst;
    assign indicator_on = q.ind_on;
    assign indicator_mode = q.ind_mode;

    // Indicator static drive, independent of display commands
    lcdc_indicator u_ind (
        .clock(clock),
        .sys_rst(sys_rst),
        .ind_mode(q.ind_mode),
        .ind_on(q.ind_on),
        .static_frame(static_frame),
        .indicator_electrode_a(indicator_electrode_a),
        .indicator_electrode_b(indicator_electrode_b)
    ); // R19 R20

    sequence s_contrast_cmd;
        cmd_wr && q.st == LCDC_IDLE && data_q == CMD_CONTRAST_MODE;
    endsequence
    sequence s_ind_cmd;
        cmd_wr && q.st == LCDC_IDLE && data_q == CMD_IND_ON;
    endsequence

    a_all_on_wins: assert property (@(posedge clock) disable iff (sys_rst) // R4
        all_on |-> pixel_drive)
        else $error("all-on not forcing pixel");
    a_inverse_map: assert property (@(posedge clock) disable iff (sys_rst) // R2
        !all_on |-> (pixel_drive == (ram_bit ^ inverse_on)))
        else $error("pixel mapping wrong");
    a_all_on_set: assert property (@(posedge clock) disable iff (sys_rst || !init_n_level) // R3
        (cmd_wr && q.st == LCDC_IDLE && data_q == CMD_ALL_ON) |=> all_on)
        else $error("all-on not set");
    a_bias_sel: assert property (@(posedge clock) disable iff (sys_rst || !init_n_level) // R5
        (cmd_wr && q.st == LCDC_IDLE && data_q == CMD_BIAS_7) |=> bias_seventh)
        else $error("bias not set");
    a_contrast_wait: assert property (@(posedge clock) disable iff (sys_rst || !init_n_level) // R14
        s_contrast_cmd |=> (q.st == LCDC_WAIT_CONTRAST))
        else $error("contrast mode not entered");
    a_contrast_load: assert property (@(posedge clock) disable iff (sys_rst || !init_n_level) // R15
        (cmd_wr && q.st == LCDC_WAIT_CONTRAST) |=>
        (lcd_drive_level == $past(data_q[CONTRAST_W-1:0]) && q.st == LCDC_IDLE))
        else $error("contrast load wrong");
    a_ind_wait: assert property (@(posedge clock) disable iff (sys_rst || !init_n_level) // R18
        s_ind_cmd |=> (indicator_on && q.st == LCDC_WAIT_INDICATOR))
        else $error("indicator wait missing");
    a_ind_load: assert property (@(posedge clock) disable iff (sys_rst || !init_n_level) // R21
        (cmd_wr && q.st == LCDC_WAIT_INDICATOR) |=> (indicator_mode == $past(data_q[IND_W-1:0])))
        else $error("indicator load wrong");
    a_ind_off: assert property (@(posedge clock) disable iff (sys_rst || !init_n_level) // R17
        (cmd_wr && q.st == LCDC_IDLE && data_q == CMD_IND_OFF) |=> !indicator_on)
        else $error("indicator not switched off");
    a_rmw_read_hold: assert property (@(posedge clock) disable iff (sys_rst || !init_n_level) // R6
        (rmw_active && rd_done && sel_level && !wr_done) |=> $stable(column_addr))
        else $error("read moved column");
    a_rmw_restore: assert property (@(posedge clock) disable iff (sys_rst || !init_n_level) // R7
        (cmd_wr && q.st == LCDC_IDLE && data_q == CMD_RMW_END && rmw_active) |=>
        (column_addr == $past(q.col_saved) && !rmw_active))
        else $error("column not restored");
    a_sw_reset: assert property (@(posedge clock) disable iff (sys_rst || !init_n_level) // R9
        (cmd_wr && q.st == LCDC_IDLE && data_q == CMD_SW_RESET) |=>
        (!rmw_active && !test_active && lcd_drive_level == CONTRAST_RST && column_addr == COL_RST))
        else $error("reset incomplete");
endmodule // lcdc_decoder
`default_nettype wire

// ### hw/lcdc_indicator.sv
`timescale 1ns/10ps
`default_nettype none
module lcdc_indicator (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [lcdc_pkg::IND_W-1:0] ind_mode,
    input wire logic ind_on,
    input wire logic static_frame,
    output logic indicator_electrode_a,
    output logic indicator_electrode_b
);
    import lcdc_pkg::*;
    typedef struct packed {
        logic [BLINK_CNT_W-1:0] cnt;
        logic phase;
        logic elec_a;
        logic elec_b;
    } lcdc_ind_t;
    lcdc_ind_t q, d;
    logic lit;
    logic [BLINK_CNT_W-1:0] period;
    // Blink half period chosen by mode
    always_comb begin
        period = (ind_mode == IND_BLINK_FAST) ? BLINK_CNT_W'(HALF_SEC_CYC - 1) : BLINK_CNT_W'(ONE_SEC_CYC - 1);
        case (ind_mode)
            IND_OFF: lit = 1'b0;
            IND_STEADY: lit = 1'b1;
            default: lit = q.phase;
        endcase
        if (!ind_on) begin
            lit = 1'b0;
        end
        d = q;
        if (q.cnt >= period) begin
            d.cnt = '0;
            d.phase = ~q.phase;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
        // Static drive: lit drives electrodes in antiphase, off keeps them equal
        d.elec_a = static_frame; // R20
        d.elec_b = lit ? ~static_frame : static_frame; // R20
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign indicator_electrode_a = q.elec_a;
    assign indicator_electrode_b = q.elec_b;
endmodule // lcdc_indicator
`default_nettype wire

// ### hw/lcdc_pkg.sv
package lcdc_pkg;
    // Command bytes
    localparam logic [7:0] CMD_NORMAL = 8'hA6;
    localparam logic [7:0] CMD_INVERSE = 8'hA7;
    localparam logic [7:0] CMD_ALL_OFF = 8'hA4;
    localparam logic [7:0] CMD_ALL_ON = 8'hA5;
    localparam logic [7:0] CMD_BIAS_9 = 8'hA2;
    localparam logic [7:0] CMD_BIAS_7 = 8'hA3;
    localparam logic [7:0] CMD_RMW = 8'hE0;
    localparam logic [7:0] CMD_RMW_END = 8'hEE;
    localparam logic [7:0] CMD_SW_RESET = 8'hE2;
    localparam logic [7:0] CMD_CONTRAST_MODE = 8'h81;
    localparam logic [7:0] CMD_IND_OFF = 8'hAC;
    localparam logic [7:0] CMD_IND_ON = 8'hAD;
    localparam logic [7:0] CMD_NOP = 8'hE3;
    // Grouped commands: upper bits matched under a mask
    localparam logic [7:0] CMD_SCAN_BASE = 8'hC0;
    localparam logic [7:0] CMD_SCAN_MASK = 8'hF0;
    localparam int SCAN_DIR_BIT = 3;
    localparam logic [7:0] CMD_RATIO_BASE = 8'h20;
    localparam logic [7:0] CMD_RATIO_MASK = 8'hF8;
    localparam logic [7:0] CMD_TEST_BASE = 8'hF0;
    localparam logic [7:0] CMD_TEST_MASK = 8'hF0;
    // Column address set commands, upper/lower nibble
    localparam logic [7:0] CMD_COLH_BASE = 8'h10;
    localparam logic [7:0] CMD_COLL_BASE = 8'h00;
    localparam logic [7:0] CMD_COL_MASK = 8'hF0;
    // Field widths
    localparam int RATIO_W = 3;
    localparam int CONTRAST_W = 6;
    localparam int IND_W = 2;
    localparam int COL_W = 8;
    // Reset values
    localparam logic [RATIO_W-1:0] RATIO_RST = 3'h0;
    localparam logic [CONTRAST_W-1:0] CONTRAST_RST = 6'h20;
    localparam logic [IND_W-1:0] IND_RST = 2'h0;
    localparam logic [COL_W-1:0] COL_RST = 8'h00;
    // Indicator modes
    localparam logic [IND_W-1:0] IND_OFF = 2'h0;
    localparam logic [IND_W-1:0] IND_BLINK_FAST = 2'h1;
    localparam logic [IND_W-1:0] IND_BLINK_SLOW = 2'h2;
    localparam logic [IND_W-1:0] IND_STEADY = 2'h3;
    // Timing
    localparam int CLK_HZ = 10000000;
    localparam int HALF_SEC_MS = 500;
    localparam int ONE_SEC_MS = 1000;
    localparam int HALF_SEC_CYC = CLK_HZ / 1000 * HALF_SEC_MS;
    localparam int ONE_SEC_CYC = CLK_HZ / 1000 * ONE_SEC_MS;
    localparam int BLINK_CNT_W = 24;
    // Decoder states
    typedef enum logic [1:0] {
        LCDC_IDLE = 2'b00,
        LCDC_WAIT_CONTRAST = 2'b01,
        LCDC_WAIT_INDICATOR = 2'b10
    } lcdc_state_t;
    // Column address counter actions
    typedef enum logic [2:0] {
        LCDC_COL_HOLD = 3'b000,
        LCDC_COL_INC = 3'b001,
        LCDC_COL_LOAD_HI = 3'b010,
        LCDC_COL_LOAD_LO = 3'b011,
        LCDC_COL_RESTORE = 3'b100,
        LCDC_COL_CLEAR = 3'b101
    } lcdc_col_op_t;
endpackage

// ### hw/lcdc_strobe_sync.sv
`timescale 1ns/10ps
`default_nettype none
module lcdc_strobe_sync #(
    parameter logic IDLE_LVL = 1'b1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic pin_in,
    output logic level_out,
    output logic rise_pulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } lcdc_sync_t;
    lcdc_sync_t q, d;
    // Three stages; a change counts once stages two and three agree
    always_comb begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
    end
    // Stages start at the pin's idle level, so release makes no false edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= {$bits(q){IDLE_LVL}};
        end else begin
            q <= d;
        end
    end
    assign level_out = q.lvl;
    assign rise_pulse = d.lvl & ~q.lvl;
endmodule // lcdc_strobe_sync
`default_nettype wire

// ### tb/lcdc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host processor on the parallel port; drives every pin at the falling edge
module lcdc_host_model (
    input wire logic clock,
    output logic host_wr_n,
    output logic host_rd_n,
    output logic cmd_data_select,
    output logic [7:0] host_data
);
    // Idle bus at time zero
    initial begin
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        cmd_data_select = 1'b0;
        host_data = 8'h00;
    end

    // One transfer: strobe low four clocks, high six; bus held until the synced strobe rises
    task automatic xfer(input logic wr, input logic sel, input logic [7:0] d);
        @(negedge clock);
        cmd_data_select = sel;
        host_data = d;
        if (wr) begin
            host_wr_n = 1'b0;
        end else begin
            host_rd_n = 1'b0;
        end
        repeat (4) @(negedge clock);
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        repeat (5) @(negedge clock);
        host_data = ~host_data;
        @(negedge clock);
    endtask
endmodule // lcdc_host_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import lcdc_pkg::*;
    typedef struct packed {
        logic inv, all, b7, scan, rmw, test, ion, pix, bact, ec, lit;
        logic [1:0] mode;
        logic [2:0] ratio;
        logic [5:0] con;
        logic [7:0] col;
    } lcdc_note_t;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic hard_init_pin_n = 1'b0;
    logic follower_on = 1'b0;
    logic static_frame = 1'b0;
    logic ram_bit = 1'b0;
    logic host_wr_n, host_rd_n, cmd_data_select;
    logic [7:0] host_data;
    logic pixel_drive, inverse_on, all_on, bias_seventh, bias_active, scan_reverse, rmw_active, test_active;
    logic soft_reset_pulse, indicator_on, indicator_electrode_a, indicator_electrode_b;
    logic [RATIO_W-1:0] regulator_resistor_ratio;
    logic [CONTRAST_W-1:0] lcd_drive_level;
    logic [COL_W-1:0] column_addr;
    logic [IND_W-1:0] indicator_mode;
    logic s_inv, s_all, s_b7, s_scan, s_rmw, s_test, s_ion;
    logic [1:0] s_mode, s_pend;
    logic [2:0] s_ratio;
    logic [5:0] s_con;
    logic [7:0] s_col, s_save;
    lcdc_note_t notes [$];
    lcdc_note_t n;
    int bad_count = 0;
    int compares = 0;
    int pulses = 0;
    logic [7:0] seq [$] = '{CMD_INVERSE, CMD_ALL_ON, CMD_NORMAL, CMD_ALL_OFF, CMD_INVERSE, CMD_BIAS_7, CMD_BIAS_9,
        CMD_CONTRAST_MODE, 8'hE5, CMD_CONTRAST_MODE, CMD_ALL_ON, CMD_IND_ON, 8'hFF, CMD_IND_ON, 8'h7E,
        CMD_IND_ON, 8'h85, CMD_IND_OFF, CMD_IND_ON, 8'hF3, CMD_ALL_ON, CMD_INVERSE, CMD_ALL_OFF, CMD_NORMAL,
        CMD_IND_ON, 8'h00, 8'hF5, CMD_NOP};

    always #50 clock = ~clock;
    always #800 static_frame = ~static_frame;

    lcdc_host_model host_u (.clock(clock), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
        .cmd_data_select(cmd_data_select), .host_data(host_data));

    lcdc_decoder dut_u (.clock(clock), .sys_rst(sys_rst), .hard_init_pin_n(hard_init_pin_n),
        .host_wr_n(host_wr_n), .host_rd_n(host_rd_n), .cmd_data_select(cmd_data_select),
        .host_data(host_data), .follower_on(follower_on), .static_frame(static_frame), .ram_bit(ram_bit),
        .pixel_drive(pixel_drive), .inverse_on(inverse_on), .all_on(all_on), .bias_seventh(bias_seventh),
        .bias_active(bias_active), .scan_reverse(scan_reverse),
        .regulator_resistor_ratio(regulator_resistor_ratio), .lcd_drive_level(lcd_drive_level),
        .column_addr(column_addr), .rmw_active(rmw_active), .test_active(test_active),
        .soft_reset_pulse(soft_reset_pulse), .indicator_on(indicator_on), .indicator_mode(indicator_mode),
        .indicator_electrode_a(indicator_electrode_a), .indicator_electrode_b(indicator_electrode_b));

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Record the expected state, then keep inputs still through the next rising edge
    task automatic note();
        lcdc_note_t m;
        m = '{s_inv, s_all, s_b7, s_scan, s_rmw, s_test, s_ion, s_all | (ram_bit ^ s_inv), follower_on,
            !s_ion || s_mode == IND_OFF || s_mode == IND_STEADY, s_ion && s_mode == IND_STEADY,
            s_mode, s_ratio, s_con, s_col};
        notes.push_back(m);
        @(negedge clock);
    endtask

    // Default values of the settings that any reset restores, plus inverse, all-on and bias when all_too is set
    task automatic dflt(input logic all_too);
        if (all_too) begin
            s_inv = 1'b0;
            s_all = 1'b0;
            s_b7 = 1'b0;
        end
        s_scan = 1'b0;
        s_rmw = 1'b0;
        s_test = 1'b0;
        s_ion = 1'b0;
        s_mode = IND_RST;
        s_ratio = RATIO_RST;
        s_con = CONTRAST_RST;
        s_col = COL_RST;
        s_pend = 2'h0;
    endtask

    // Write one command byte and update the expected state
    task automatic cmd(input logic [7:0] b);
        logic [1:0] p;
        ram_bit = 1'($urandom);
        follower_on = 1'($urandom);
        host_u.xfer(1'b1, 1'b0, b);
        p = s_pend;
        s_pend = 2'h0;
        if (p == 2'h1) s_con = b[5:0];
        else if (p == 2'h2) s_mode = b[1:0];
        else if (b == CMD_NORMAL || b == CMD_INVERSE) s_inv = b[0];
        else if (b == CMD_ALL_OFF || b == CMD_ALL_ON) s_all = b[0];
        else if (b == CMD_BIAS_9 || b == CMD_BIAS_7) s_b7 = b[0];
        else if (b == CMD_CONTRAST_MODE) s_pend = 2'h1;
        else if (b == CMD_IND_OFF) s_ion = 1'b0;
        else if (b == CMD_SW_RESET) dflt(1'b0);
        else if (b == CMD_NOP) s_test = 1'b0;
        else if (b == CMD_IND_ON) begin
            s_ion = 1'b1;
            s_pend = 2'h2;
        end else if (b == CMD_RMW) begin
            s_rmw = 1'b1;
            s_save = s_col;
        end else if (b == CMD_RMW_END) begin
            if (s_rmw) s_col = s_save;
            s_rmw = 1'b0;
        end
        else if ((b & CMD_SCAN_MASK) == CMD_SCAN_BASE) s_scan = b[SCAN_DIR_BIT];
        else if ((b & CMD_RATIO_MASK) == CMD_RATIO_BASE) s_ratio = b[2:0];
        else if ((b & CMD_TEST_MASK) == CMD_TEST_BASE) s_test = 1'b1;
        else if ((b & CMD_COL_MASK) == CMD_COLH_BASE) s_col[7:4] = b[3:0];
        else if ((b & CMD_COL_MASK) == CMD_COLL_BASE) s_col[3:0] = b[3:0];
        if (s_pend == 2'h0) note();
    endtask

    // Display data transfer; the byte carries no command
    task automatic dat(input logic wr);
        host_u.xfer(wr, 1'b1, wr ? CMD_INVERSE : 8'h00);
        if ((wr || !s_rmw) && s_col != 8'hFF) s_col = s_col + 8'h01;
        note();
    endtask

    // Watch the outputs and compare with the oldest note
    always @(posedge clock) begin
        if (soft_reset_pulse === 1'b1) pulses++;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            check({7'h00, inverse_on}, {7'h00, n.inv});
            check({7'h00, all_on}, {7'h00, n.all});
            check({7'h00, pixel_drive}, {7'h00, n.pix});
            check({6'h00, bias_active, bias_seventh}, {6'h00, n.bact, n.b7});
            check({7'h00, scan_reverse}, {7'h00, n.scan});
            check({5'h00, regulator_resistor_ratio}, {5'h00, n.ratio});
            check({2'h0, lcd_drive_level}, {2'h0, n.con});
            check(column_addr, n.col);
            check({6'h00, rmw_active, test_active}, {6'h00, n.rmw, n.test});
            check({5'h00, indicator_on, indicator_mode}, {5'h00, n.ion, n.mode});
            if (n.ec) check({7'h00, indicator_electrode_a ^ indicator_electrode_b}, {7'h00, n.lit});
        end
    end

    // Hang guard, well beyond the expected run of under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(63));
        dflt(1'b1);
        repeat (6) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        hard_init_pin_n = 1'b1;
        repeat (6) @(negedge clock);
        note();
        foreach (seq[i]) cmd(seq[i]);
        for (int i = 0; i < 8; i++) cmd(CMD_RATIO_BASE | 8'(i));
        for (int i = 0; i < 6; i++) cmd(CMD_SCAN_BASE | 8'($urandom_range(15)));
        cmd(8'h1F);
        cmd(8'h0E);
        dat(1'b1);
        dat(1'b1);
        cmd(8'h13);
        cmd(8'h02);
        dat(1'b0);
        cmd(CMD_RMW);
        dat(1'b0);
        dat(1'b1);
        dat(1'b1);
        cmd(CMD_ALL_ON);
        cmd(CMD_RMW_END);
        cmd(CMD_RMW);
        cmd(CMD_IND_ON);
        cmd(8'h03);
        cmd(CMD_CONTRAST_MODE);
        cmd(8'h11);
        cmd(8'hF9);
        pulses = 0;
        cmd(CMD_SW_RESET);
        check(8'(pulses), 8'h01);
        cmd(CMD_INVERSE);
        cmd(8'h25);
        cmd(8'h07);
        cmd(CMD_RMW_END);
        @(negedge clock);
        hard_init_pin_n = 1'b0;
        repeat (8) @(negedge clock);
        hard_init_pin_n = 1'b1;
        dflt(1'b1);
        repeat (6) @(negedge clock);
        note();
        repeat (4) @(negedge clock);
        wrap_up();
    end
endmodule // tb
`default_nettype wire
